// *** logic/asrl_top.sv ***
// Addressable serial remote link: UART framing, control-code decoder,
// listen/talk addressing, XON/XOFF, remote/local state, APB registers.
// Assumes rxd is already synchronous to core_clk and an APB master.
//
// How it works
// - Frames: start, eight data, no parity, stop.
// - Received bit seven is forced to zero outside locked mode.
// - Commands offered case-folded for mnemonic matching.
// - Undefined codes below 20H are ignored.
// - Power-on enters non-addressable mode.
// - Code 04H locks non-addressable mode until reset.
// - Code 02H enables addressable mode.
// - 12H plus own address enters listen.
// - Accepted listen address sends acknowledge 06H.
// - Listen ends on other listen, talk, 03H/04H/18H.
// - 14H plus own address enters talk, one response.
// - Talk ends on listen, other talk, 03H/04H/18H.
// - Talk ends after response or without one.
// - Line feed terminates commands and responses.
// - Carriage return in commands is discarded.
// - XOFF pauses talker until XON.
// - Binary data only in locked mode.
// - Five-bit address reaches all 32, including 31.
// - Commands set remote; local key reverts until next.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module asrl_top #(
  parameter int CLK_HZ = asrl_pkg::CLK_HZ_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             remote_lamp
);
  import asrl_pkg::*;

  asrl_cfg_t          cfg_reg;
  asrl_mode_t         mode_reg;
  asrl_pend_t         pend_reg;
  asrl_ser_t          rx_state_reg;
  asrl_ser_t          tx_state_reg;
  asrl_rxchar_t       rxchar_reg;
  asrl_status_t       status;
  logic               listen_reg;
  logic               talk_reg;
  logic               xoff_reg;
  logic               ack_pend_reg;
  logic               resp_ready_reg;
  logic               frame_err_reg;
  logic               overrun_reg;
  logic               rxd_q_reg;
  logic [DIV_W-1:0]   baud_div;
  logic [DIV_W+3:0]   ack_wait_reg;
  logic [DIV_W-1:0]   rx_cnt_reg;
  logic [DIV_W-1:0]   tx_cnt_reg;
  logic [2:0]         rx_bit_reg;
  logic [2:0]         tx_bit_reg;
  logic [7:0]         rx_shift_reg;
  logic [7:0]         tx_shift_reg;
  logic [7:0]         tx_hold_reg;
  logic               tx_hold_valid_reg;
  logic               tx_is_lf_reg;
  logic               rx_done;
  logic               rx_bad_stop;
  logic [7:0]         rx_byte;
  logic               addr_hit;
  logic               rx_accept;
  logic               tx_load_ack;
  logic               tx_load_data;
  logic               tx_lf_done;
  logic               apb_wr;
  logic               apb_rd;
  logic [31:0]        rd_data;
  logic               rd_hit;

  // Bit timing shared by both directions.
  always_comb begin
    baud_div = DIV_W'(CLK_HZ / BAUD_RATE[cfg_reg.baud_sel]);
  end

  // Receiver samples each bit at its middle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxd_q_reg    <= 1'b1;
      rx_state_reg <= SER_IDLE;
      rx_cnt_reg   <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
    end else begin
      rxd_q_reg <= rxd;
      case (rx_state_reg)
        SER_IDLE: begin
          if (!rxd_q_reg) begin
            rx_cnt_reg   <= baud_div >> 1;
            rx_state_reg <= SER_START;
          end
        end
        SER_START: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else if (rxd_q_reg) begin
            rx_state_reg <= SER_IDLE;
          end else begin
            rx_cnt_reg   <= baud_div - 1'b1;
            rx_bit_reg   <= '0;
            rx_state_reg <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_shift_reg <= {rxd_q_reg, rx_shift_reg[7:1]};
            rx_cnt_reg   <= baud_div - 1'b1;
            rx_bit_reg   <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == 3'(DATA_BITS - 1)) begin
              rx_state_reg <= SER_STOP;
            end
          end
        end
        default: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_state_reg <= SER_IDLE;
          end
        end
      endcase
    end
  end

  // Decode of the received character.
  always_comb begin
    rx_done     = rx_state_reg == SER_STOP && rx_cnt_reg == '0 && rxd_q_reg;
    rx_bad_stop = rx_state_reg == SER_STOP && rx_cnt_reg == '0 && !rxd_q_reg;
    rx_byte     = rx_shift_reg;
    if (mode_reg != MODE_LOCKED) begin
      rx_byte[7] = 1'b0;
    end
    addr_hit  = rx_byte[4:0] == cfg_reg.addr;
    rx_accept = 1'b0;
    if (rx_done) begin
      if (mode_reg == MODE_LOCKED) begin
        rx_accept = 1'b1;
      end else if (rx_byte < CODE_SPACE && rx_byte != CODE_LF) begin
        rx_accept = 1'b0;
      end else if (mode_reg == MODE_NONADDR) begin
        rx_accept = 1'b1;
      end else begin
        rx_accept = listen_reg && pend_reg == PEND_NONE;
      end
    end
  end

  // Mode, addressing and flow-control state.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_reg   <= MODE_NONADDR;
      pend_reg   <= PEND_NONE;
      listen_reg <= 1'b0;
      talk_reg   <= 1'b0;
      xoff_reg   <= 1'b0;
    end else begin
      if (talk_reg && (!resp_ready_reg || tx_lf_done)) begin
        talk_reg <= 1'b0;
      end
      if (rx_done && mode_reg != MODE_LOCKED) begin
        if (pend_reg != PEND_NONE) begin
          pend_reg <= PEND_NONE;
          if (pend_reg == PEND_LISTEN) begin
            listen_reg <= addr_hit;
          end else begin
            talk_reg <= addr_hit;
          end
        end else begin
          case (rx_byte)
            CODE_LOCK: begin
              mode_reg   <= MODE_LOCKED;
              listen_reg <= 1'b0;
              talk_reg   <= 1'b0;
              xoff_reg   <= 1'b0;
            end
            CODE_SET_ADDR: begin
              mode_reg <= MODE_ADDR;
            end
            CODE_XOFF: begin
              xoff_reg <= 1'b1;
            end
            CODE_XON: begin
              xoff_reg <= 1'b0;
            end
            CODE_LISTEN: begin
              if (mode_reg == MODE_ADDR) begin
                pend_reg <= PEND_LISTEN;
                talk_reg <= 1'b0;
              end
            end
            CODE_TALK: begin
              if (mode_reg == MODE_ADDR) begin
                pend_reg   <= PEND_TALK;
                listen_reg <= 1'b0;
              end
            end
            CODE_UNADDR, CODE_CLEAR: begin
              listen_reg <= 1'b0;
              talk_reg   <= 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Acknowledge request; a new listen address wins over the send.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_pend_reg <= 1'b0;
    end else if (rx_done && mode_reg == MODE_ADDR && pend_reg == PEND_LISTEN
                 && addr_hit) begin
      ack_pend_reg <= 1'b1;
    end else if (tx_load_ack) begin
      ack_pend_reg <= 1'b0;
    end
  end

  // Remote lamp; any accepted character or own addressing sets it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      remote_lamp <= 1'b0;
    end else if (rx_accept || (rx_done && pend_reg != PEND_NONE
                 && mode_reg == MODE_ADDR && addr_hit)) begin
      remote_lamp <= 1'b1;
    end else if (apb_wr && paddr == ADDR_CMD && pwdata[CMD_LOCAL_BIT]) begin
      remote_lamp <= 1'b0;
    end
  end

  // Received command character holding register and error flags.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxchar_reg    <= '0;
      frame_err_reg <= 1'b0;
      overrun_reg   <= 1'b0;
    end else begin
      if (apb_rd && paddr == ADDR_RXDATA) begin
        rxchar_reg.valid <= 1'b0;
      end
      if (apb_wr && paddr == ADDR_STATUS) begin
        if (pwdata[STS_FRAME_BIT]) begin
          frame_err_reg <= 1'b0;
        end
        if (pwdata[STS_OVERRUN_BIT]) begin
          overrun_reg <= 1'b0;
        end
      end
      if (rx_bad_stop) begin
        frame_err_reg <= 1'b1;
      end
      if (rx_accept) begin
        rxchar_reg.valid <= 1'b1;
        rxchar_reg.data  <= rx_byte;
        rxchar_reg.term  <= rx_byte == CODE_LF;
        rxchar_reg.folded <= rx_byte;
        if (mode_reg != MODE_LOCKED && rx_byte >= CHAR_LC_A
            && rx_byte <= CHAR_LC_Z) begin
          rxchar_reg.folded <= rx_byte & ~CODE_SPACE;
        end
        if (rxchar_reg.valid && !(apb_rd && paddr == ADDR_RXDATA)) begin
          overrun_reg <= 1'b1;
        end
      end
    end
  end

  // Transmit source choice; the acknowledge ignores XOFF pause.
  always_comb begin
    tx_load_ack  = tx_state_reg == SER_IDLE && ack_pend_reg;
    tx_load_data = tx_state_reg == SER_IDLE && !ack_pend_reg
                   && tx_hold_valid_reg && !xoff_reg
                   && (mode_reg != MODE_ADDR || talk_reg);
    tx_lf_done   = tx_state_reg == SER_STOP && tx_cnt_reg == '0
                   && tx_is_lf_reg;
  end

  // Response holding byte and response-ready flag.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_hold_reg       <= '0;
      tx_hold_valid_reg <= 1'b0;
      resp_ready_reg    <= 1'b0;
    end else begin
      if (tx_load_data) begin
        tx_hold_valid_reg <= 1'b0;
      end else if (apb_wr && paddr == ADDR_TXDATA && !tx_hold_valid_reg) begin
        tx_hold_reg       <= pwdata[7:0];
        tx_hold_valid_reg <= 1'b1;
      end
      if (apb_wr && paddr == ADDR_CMD && pwdata[CMD_RESP_BIT]) begin
        resp_ready_reg <= 1'b1;
      end else if (tx_lf_done) begin
        resp_ready_reg <= 1'b0;
      end
    end
  end

  // Transmitter shifts LSB first after a start bit.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_reg <= SER_IDLE;
      txd          <= 1'b1;
      tx_cnt_reg   <= '0;
      tx_bit_reg   <= '0;
      tx_shift_reg <= '0;
      tx_is_lf_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        SER_IDLE: begin
          if (tx_load_ack || tx_load_data) begin
            tx_shift_reg <= tx_load_ack ? CODE_ACK : tx_hold_reg;
            tx_is_lf_reg <= tx_load_data && tx_hold_reg == CODE_LF;
            txd          <= 1'b0;
            tx_cnt_reg   <= baud_div - 1'b1;
            tx_state_reg <= SER_START;
          end
        end
        SER_START: begin
          if (tx_cnt_reg != '0) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
          end else begin
            txd          <= tx_shift_reg[0];
            tx_cnt_reg   <= baud_div - 1'b1;
            tx_bit_reg   <= '0;
            tx_state_reg <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (tx_cnt_reg != '0) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
          end else begin
            tx_cnt_reg <= baud_div - 1'b1;
            if (tx_bit_reg == 3'(DATA_BITS - 1)) begin
              txd          <= 1'b1;
              tx_state_reg <= SER_STOP;
            end else begin
              tx_shift_reg <= tx_shift_reg >> 1;
              txd          <= tx_shift_reg[1];
              tx_bit_reg   <= tx_bit_reg + 1'b1;
            end
          end
        end
        default: begin
          if (tx_cnt_reg != '0) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
          end else begin
            tx_is_lf_reg <= 1'b0;
            tx_state_reg <= SER_IDLE;
          end
        end
      endcase
    end
  end

  // Configuration register.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RST;
    end else if (apb_wr && paddr == ADDR_CFG) begin
      cfg_reg <= asrl_cfg_t'(pwdata[7:0]);
    end
  end

  // APB decode; zero wait states, unmapped addresses answer an error.
  always_comb begin
    status.tx_busy    = tx_state_reg != SER_IDLE;
    status.ack_pend   = ack_pend_reg;
    status.overrun    = overrun_reg;
    status.frame_err  = frame_err_reg;
    status.rx_valid   = rxchar_reg.valid;
    status.resp_ready = resp_ready_reg;
    status.tx_full    = tx_hold_valid_reg;
    status.remote     = remote_lamp;
    status.xoff       = xoff_reg;
    status.talk       = talk_reg;
    status.listen     = listen_reg;
    status.mode       = mode_reg;
    rd_hit  = 1'b1;
    rd_data = '0;
    if (paddr == ADDR_CFG) begin
      rd_data = {24'h000000, cfg_reg};
    end else if (paddr == ADDR_STATUS) begin
      rd_data = {19'h00000, status};
    end else if (paddr == ADDR_RXDATA) begin
      rd_data = {14'h0000, rxchar_reg};
    end else if (paddr == ADDR_TXDATA || paddr == ADDR_CMD) begin
      rd_data = '0;
    end else begin
      rd_hit = 1'b0;
    end
    apb_wr = psel && penable && pready && pwrite && rd_hit;
    apb_rd = psel && penable && pready && !pwrite && rd_hit;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
      end
    end
  end

  // Cycles an acknowledge has waited; bounded by sixteen bit times in the checks.
  always_ff @(posedge core_clk) begin
    if (!rst_n || !ack_pend_reg) begin
      ack_wait_reg <= '0;
    end else begin
      ack_wait_reg <= ack_wait_reg + 1'b1;
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_RESET_NONADDR: assert property (@(posedge core_clk)
    $rose(rst_n) |-> mode_reg == MODE_NONADDR && !listen_reg && !talk_reg)
    else $error("Mode after reset is not non-addressable.");

  AST_LOCK_STICKY: assert property (
    mode_reg == MODE_LOCKED |=> mode_reg == MODE_LOCKED [*3])
    else $error("Locked mode was left.");

  AST_SET_ADDR: assert property (
    rx_done && mode_reg == MODE_NONADDR && pend_reg == PEND_NONE
    && rx_byte == CODE_SET_ADDR |=> mode_reg == MODE_ADDR)
    else $error("Code 02H did not enable addressable mode.");

  AST_LISTEN_ACK: assert property (
    rx_done && mode_reg == MODE_ADDR && pend_reg == PEND_LISTEN && addr_hit
    |=> listen_reg && ack_pend_reg)
    else $error("Own listen address gave no acknowledge.");

  AST_ACK_WAIT: assert property (
    ack_wait_reg < {baud_div, 4'h0})
    else $error("Acknowledge waited too long for the transmitter.");

  AST_ACK_CODE: assert property (
    tx_load_ack |=> tx_shift_reg == CODE_ACK && tx_state_reg == SER_START)
    else $error("Acknowledge load started a wrong code.");

  AST_LISTEN_END: assert property (
    rx_done && mode_reg == MODE_ADDR && pend_reg == PEND_NONE
    && (rx_byte == CODE_TALK || rx_byte == CODE_UNADDR
    || rx_byte == CODE_CLEAR || rx_byte == CODE_LOCK) |=> !listen_reg)
    else $error("Listen state survived a cancelling code.");

  AST_TALK_NORESP: assert property (
    talk_reg && !resp_ready_reg && !rx_done |=> !talk_reg)
    else $error("Talk state held with no response.");

  AST_XOFF_HOLD: assert property (
    xoff_reg && tx_state_reg == SER_IDLE
    |=> tx_state_reg == SER_IDLE || tx_shift_reg == CODE_ACK)
    else $error("Response data sent while paused.");

  AST_CR_DROP: assert property (
    rx_done && mode_reg != MODE_LOCKED && rx_byte == CODE_CR
    |=> $stable(rxchar_reg.data))
    else $error("Carriage return reached the command stream.");

  AST_IGNORE_CTRL: assert property (
    rx_done && mode_reg != MODE_LOCKED && pend_reg == PEND_NONE
    && rx_byte == 8'h01 |=> $stable(mode_reg) && $stable(pend_reg)
    && $stable(xoff_reg) && $stable(listen_reg))
    else $error("Undefined control code changed state.");

  AST_REMOTE: assert property (
    rx_accept |=> remote_lamp && rxchar_reg.valid)
    else $error("Accepted command did not enter remote state.");

  AST_MSB_ZERO: assert property (
    rx_accept && mode_reg != MODE_LOCKED |=> !rxchar_reg.data[7])
    else $error("Bit seven of a received character was kept.");

endmodule

// *** shared/asrl_pkg.sv ***
// Constants, codes, register map and carriers of the addressable serial link.
// Assumes a single 250 MHz clock domain and an APB register bus.
package asrl_pkg;

  localparam int          DATA_BITS   = 8;
  localparam int          DIV_W       = 24;
  localparam int          CLK_HZ_DEF  = 250_000_000;
  localparam int          BAUD_RATE [8] = '{300, 600, 1200, 2400,
                                            4800, 9600, 19200, 38400};

  localparam logic [7:0]  CODE_SET_ADDR = 8'h02;
  localparam logic [7:0]  CODE_UNADDR   = 8'h03;
  localparam logic [7:0]  CODE_LOCK     = 8'h04;
  localparam logic [7:0]  CODE_ACK      = 8'h06;
  localparam logic [7:0]  CODE_LF       = 8'h0A;
  localparam logic [7:0]  CODE_CR       = 8'h0D;
  localparam logic [7:0]  CODE_XON      = 8'h11;
  localparam logic [7:0]  CODE_LISTEN   = 8'h12;
  localparam logic [7:0]  CODE_XOFF     = 8'h13;
  localparam logic [7:0]  CODE_TALK     = 8'h14;
  localparam logic [7:0]  CODE_CLEAR    = 8'h18;
  localparam logic [7:0]  CODE_SPACE    = 8'h20;
  localparam logic [7:0]  CHAR_LC_A     = 8'h61;
  localparam logic [7:0]  CHAR_LC_Z     = 8'h7A;

  localparam logic [7:0]  ADDR_CFG    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_RXDATA = 8'h08;
  localparam logic [7:0]  ADDR_TXDATA = 8'h0C;
  localparam logic [7:0]  ADDR_CMD    = 8'h10;

  localparam int          CMD_LOCAL_BIT   = 0;
  localparam int          CMD_RESP_BIT    = 1;
  localparam int          STS_FRAME_BIT   = 9;
  localparam int          STS_OVERRUN_BIT = 10;

  typedef enum logic [1:0] {MODE_NONADDR, MODE_ADDR, MODE_LOCKED} asrl_mode_t;
  typedef enum logic [1:0] {PEND_NONE, PEND_LISTEN, PEND_TALK} asrl_pend_t;
  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA,
                            SER_STOP} asrl_ser_t;

  typedef struct packed {
    logic [2:0] baud_sel;
    logic [4:0] addr;
  } asrl_cfg_t;

  localparam asrl_cfg_t   CFG_RST = '{baud_sel: 3'h5, addr: 5'h00};

  typedef struct packed {
    logic       valid;
    logic       term;
    logic [7:0] folded;
    logic [7:0] data;
  } asrl_rxchar_t;

  typedef struct packed {
    logic       tx_busy;
    logic       ack_pend;
    logic       overrun;
    logic       frame_err;
    logic       rx_valid;
    logic       resp_ready;
    logic       tx_full;
    logic       remote;
    logic       xoff;
    logic       talk;
    logic       listen;
    asrl_mode_t mode;
  } asrl_status_t;

endpackage

// *** verification/asrl_host_model.sv ***
// Host-side serial model: sends characters on the device receive line and
// collects what the device transmits. Assumes 8N1 at DIV cycles per bit.
`timescale 1ns/1ns
module asrl_host_model #(
  parameter int DIV = 20
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got;
  logic [7:0] rx_q [$];
  int         bad_stop;

  initial rxd = 1'b1;
  initial bad_stop = 0;

  // Start bit, eight data bits LSB first, one stop bit, no parity.
  task automatic send(input logic [7:0] c);
    logic [9:0] frame;
    frame = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      rxd <= frame[i];
      repeat (DIV - 1) @(posedge core_clk);
    end
  endtask

  // Samples each bit of a device frame in its middle.
  always begin
    @(posedge core_clk);
    if (rst_n === 1'b1 && txd === 1'b0) begin
      repeat (DIV / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge core_clk);
        got[i] = txd;
      end
      repeat (DIV) @(posedge core_clk);
      if (txd === 1'b1) begin
        rx_q.push_back(got);
      end else begin
        bad_stop++;
      end
    end
  end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the addressable serial link: APB tasks and a
// host serial model. Assumes asrl_top and asrl_pkg.
`timescale 1ns/1ns
module tb;
  import asrl_pkg::*;
  localparam int SIM_HZ = 768_000;
  localparam int DIV    = SIM_HZ / BAUD_RATE[7];

  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        remote_lamp;
  logic [31:0] d;
  logic        serr;
  int          errors;
  int          n_compared;
  int          cycles;

  asrl_top #(.CLK_HZ(SIM_HZ)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
    .remote_lamp(remote_lamp)
  );

  asrl_host_model #(.DIV(DIV)) host (
    .core_clk(core_clk), .rst_n(rst_n), .txd(txd), .rxd(rxd)
  );

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Setup cycle, then access held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    d       = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic expect_rx(input logic [7:0] e);
    while (host.rx_q.size() == 0) @(posedge core_clk);
    chk("tx char", {24'h0, e}, {24'h0, host.rx_q.pop_front()});
  endtask

  task automatic s_regs();
    rd(ADDR_CFG);
    chk("cfg reset", 32'h0000_00A0, d);
    apb(1'b1, ADDR_CFG, 32'h0000_00FF);
    rd(ADDR_CFG);
    chk("cfg", 32'h0000_00FF, d);
    rd(8'h20);
    chk("slverr", 32'h0000_0001, {31'h0, serr});
    chk("unmapped", 32'h0000_0000, d);
    rd(ADDR_STATUS);
    chk("state", 32'h0000_0000, {28'h0, d[3:0]});
    chk("lamp", 32'h0000_0000, {31'h0, remote_lamp});
  endtask

  task automatic s_nonaddr();
    host.send(CODE_LISTEN);
    host.send(8'h61);
    rd(ADDR_STATUS);
    chk("state", 32'h0000_0000, {28'h0, d[3:0]});
    chk("ack count", 32'h0, 32'(host.rx_q.size()));
    rd(ADDR_RXDATA);
    chk("rxdata", 32'h0002_4161, {14'h0, d[17:0]});
    chk("lamp", 32'h0000_0001, {31'h0, remote_lamp});
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk("lamp", 32'h0000_0000, {31'h0, remote_lamp});
    host.send(8'hC1);
    rd(ADDR_RXDATA);
    chk("rxdata", 32'h0002_4141, {14'h0, d[17:0]});
    chk("lamp", 32'h0000_0001, {31'h0, remote_lamp});
    host.send(8'h01);
    rd(ADDR_RXDATA);
    chk("rx valid", 32'h0000_0000, {31'h0, d[17]});
  endtask

  task automatic s_listen();
    host.send(CODE_SET_ADDR);
    rd(ADDR_STATUS);
    chk("mode", 32'h0000_0001, {30'h0, d[1:0]});
    host.send(CODE_LISTEN);
    host.send(8'h5F);
    expect_rx(CODE_ACK);
    rd(ADDR_STATUS);
    chk("listen", 32'h0000_0001, {31'h0, d[2]});
    host.send(8'h62);
    host.send(CODE_CR);
    rd(ADDR_RXDATA);
    chk("rxdata", 32'h0002_4262, {14'h0, d[17:0]});
    host.send(CODE_LF);
    rd(ADDR_RXDATA);
    chk("rxdata", 32'h0003_0A0A, {14'h0, d[17:0]});
    host.send(CODE_LISTEN);
    host.send(8'h45);
    rd(ADDR_STATUS);
    chk("listen", 32'h0000_0000, {31'h0, d[2]});
    host.send(CODE_LISTEN);
    host.send(8'h5F);
    expect_rx(CODE_ACK);
    host.send(CODE_CLEAR);
    rd(ADDR_STATUS);
    chk("listen", 32'h0000_0000, {31'h0, d[2]});
  endtask

  task automatic s_talk();
    host.send(CODE_TALK);
    host.send(8'h5F);
    rd(ADDR_STATUS);
    chk("talk", 32'h0000_0000, {31'h0, d[3]});
    host.send(CODE_XOFF);
    apb(1'b1, ADDR_CMD, 32'h0000_0002);
    apb(1'b1, ADDR_TXDATA, 32'h0000_004B);
    host.send(CODE_TALK);
    host.send(8'h5F);
    repeat (12 * DIV) @(posedge core_clk);
    rd(ADDR_STATUS);
    chk("xoff talk", 32'h0000_0003, {30'h0, d[4:3]});
    chk("held", 32'h0, 32'(host.rx_q.size()));
    host.send(CODE_XON);
    expect_rx(8'h4B);
    apb(1'b1, ADDR_TXDATA, {24'h0, CODE_LF});
    expect_rx(CODE_LF);
    repeat (DIV) @(posedge core_clk);
    rd(ADDR_STATUS);
    chk("talk", 32'h0000_0000, {31'h0, d[3]});
  endtask

  task automatic s_lock();
    host.send(CODE_LOCK);
    host.send(CODE_SET_ADDR);
    host.send(8'hC1);
    rd(ADDR_STATUS);
    chk("mode", 32'h0000_0002, {30'h0, d[1:0]});
    chk("overrun", 32'h0000_0001, {31'h0, d[10]});
    rd(ADDR_RXDATA);
    chk("raw char", 32'h0000_01C1, {23'h0, d[17], d[7:0]});
  endtask

  initial begin
    core_clk   = 1'b0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    errors     = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    s_regs();
    s_nonaddr();
    s_listen();
    s_talk();
    s_lock();
    chk("bad stop", 32'h0, 32'(host.bad_stop));
    report_and_stop();
  end
endmodule
